// ---- dv/pae_proc_model.sv ----
// Behavioural model of the process sensor and controller output stage
`timescale 1ns/100ps
`default_nettype none

module pae_proc_model
  import pae_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire pae_proc_s next_val,
  output var pae_proc_s proc,
  output logic sample_stb
);
  logic pend_reg;

  // New values settle one cycle before the sampling tick
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      proc <= '0;
      pend_reg <= 1'b0;
      sample_stb <= 1'b0;
    end
    else
    begin
      if (load)
        proc <= next_val;
      pend_reg <= load;
      sample_stb <= pend_reg;
    end
  end
endmodule

`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking testbench of the process alarm evaluator
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import pae_pkg::*;
;
  localparam logic [15:0] S = 16'h0064;
  localparam logic [15:0] Z = 16'h0000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [PAE_AW-1:0] reg_addr = '0;
  logic [PAE_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [PAE_DW-1:0] reg_rdata;
  logic sample_stb;
  logic load = 1'b0;
  pae_proc_s next_val = '0;
  pae_proc_s proc;
  logic alarm_out;
  logic [4:0] cur_t = 5'h02;
  logic loop_break = 1'b0;
  logic [PAE_DW-1:0] rdata_ch2;
  int n_mismatch = 0;
  int compares = 0;

  pae_evaluator #(.CHANNEL(1)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_stb(sample_stb),
    .proc(proc), .loop_break_in(loop_break), .alarm_out(alarm_out));

  // Second channel: must refuse the loop break type
  pae_evaluator #(.CHANNEL(2)) dut_ch2 (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_ch2), .sample_stb(sample_stb),
    .proc(proc), .loop_break_in(loop_break), .alarm_out());

  pae_proc_model u_proc (
    .core_clk(core_clk), .sys_rst(sys_rst), .load(load), .next_val(next_val),
    .proc(proc), .sample_stb(sample_stb));

  initial
  begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // Hands one set of process values to the sensor model and checks the alarm
  task automatic st(input logic [4:0] t, input logic [15:0] x, pv, sp, mh, mc,
                    input logic hc, input logic e);
    int n;
    if (t !== cur_t)
    begin
      wr(PAE_A_TYPE, {11'h000, t});
      cur_t = t;
    end
    wr(PAE_A_VALUE, x);
    wr(PAE_A_CTRL, {15'h0000, hc});
    @(posedge core_clk);
    next_val <= '{pv, sp, mh, mc};
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
    n = 0;
    while (sample_stb !== 1'b1 && n < 10)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    #1 chk({15'h0000, alarm_out}, {15'h0000, e});
  endtask

  task automatic p(input logic [4:0] t, input logic [15:0] x, pv, input logic e);
    st(t, x, pv, S, Z, Z, 1'b0, e);
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(PAE_A_TYPE, 16'h0002);
    rd(PAE_A_VALUE, Z);
    rd(PAE_A_UPPER, Z);
    rd(PAE_A_LOWER, Z);
    rd(PAE_A_HYST, 16'h0002);
    rd(PAE_A_CTRL, Z);
    rd(4'h9, Z);
    wr(PAE_A_TYPE, 16'h0012);
    rd(PAE_A_TYPE, 16'h0002);
    wr(PAE_A_TYPE, 16'h000c);
    rd(PAE_A_TYPE, 16'h000c);
    chk(rdata_ch2, 16'h0002);
    cur_t = 5'h0c;
    wr(PAE_A_UPPER, 16'h0005);
    wr(PAE_A_LOWER, 16'h0003);
    wr(PAE_A_HYST, Z);
    rd(PAE_A_UPPER, 16'h0005);
    $display("test registers done");
    p(5'h01, Z, 16'h006a, 1'b1); p(5'h01, Z, 16'h0069, 1'b0);
    p(5'h01, Z, 16'h0061, 1'b0); p(5'h01, Z, 16'h0060, 1'b1);
    p(5'h02, 16'h0003, 16'h0067, 1'b1); p(5'h02, 16'h0003, 16'h0066, 1'b0);
    p(5'h02, 16'h0003, 16'h0067, 1'b1);
    p(5'h03, 16'h0003, 16'h0061, 1'b1); p(5'h03, 16'h0003, 16'h0062, 1'b0);
    p(5'h03, 16'h0003, 16'h0062, 1'b0);
    p(5'h04, Z, 16'h0069, 1'b1); p(5'h04, Z, 16'h0069, 1'b1);
    p(5'h04, Z, 16'h006a, 1'b0);
    p(5'h04, Z, 16'h0061, 1'b1); p(5'h04, Z, 16'h0060, 1'b0);
    p(5'h05, Z, 16'h006a, 1'b0); p(5'h05, Z, S, 1'b0);
    p(5'h05, Z, 16'h0060, 1'b1);
    p(5'h06, 16'h0003, 16'h006e, 1'b0); p(5'h06, 16'h0003, S, 1'b0);
    p(5'h06, 16'h0003, 16'h006e, 1'b1);
    p(5'h07, 16'h0003, 16'h005a, 1'b0); p(5'h07, 16'h0003, S, 1'b0);
    p(5'h07, 16'h0003, 16'h005a, 1'b1);
    p(5'h08, 16'hfffb, 16'hfffc, 1'b1); p(5'h08, 16'hfffb, 16'hfffb, 1'b0);
    p(5'h08, 16'hfffb, 16'hfffc, 1'b1);
    p(5'h09, 16'hfffb, 16'hfffa, 1'b1); p(5'h09, 16'hfffb, 16'hfffb, 1'b0);
    p(5'h09, 16'hfffb, 16'hfffb, 1'b0);
    p(5'h0a, 16'h0032, 16'h003c, 1'b0); p(5'h0a, 16'h0032, 16'h0028, 1'b0);
    p(5'h0a, 16'h0032, 16'h003c, 1'b1);
    p(5'h0b, 16'h0032, 16'h0028, 1'b0); p(5'h0b, 16'h0032, 16'h003c, 1'b0);
    p(5'h0b, 16'h0032, 16'h0028, 1'b1);
    p(5'h0d, 16'h0003, 16'h0028, 1'b0); p(5'h0d, 16'h0003, 16'h002c, 1'b1);
    p(5'h0d, 16'h0003, 16'h002c, 1'b0);
    loop_break <= 1'b1;
    p(5'h0c, Z, S, 1'b1);
    loop_break <= 1'b0;
    p(5'h0c, Z, S, 1'b0);
    $display("test process value types done");
    st(5'h0e, 16'h0032, S, 16'h0033, Z, Z, 1'b0, 1'b1);
    st(5'h0e, 16'h0032, S, 16'h0032, Z, Z, 1'b0, 1'b0);
    st(5'h0f, 16'h0032, S, 16'h0031, Z, Z, 1'b0, 1'b1);
    st(5'h0f, 16'h0032, S, 16'h0032, Z, Z, 1'b0, 1'b0);
    st(5'h10, 16'h0032, S, S, 16'h0033, Z, 1'b0, 1'b1);
    st(5'h10, 16'h0032, S, S, 16'h0032, Z, 1'b0, 1'b0);
    st(5'h10, 16'h0032, S, S, 16'h0033, Z, 1'b1, 1'b1);
    st(5'h10, 16'h0032, S, S, Z, 16'h0040, 1'b1, 1'b0);
    st(5'h11, 16'h0032, S, S, 16'h0031, 16'h0040, 1'b0, 1'b1);
    st(5'h11, 16'h0032, S, S, 16'h0032, Z, 1'b0, 1'b0);
    st(5'h11, 16'h0032, S, S, 16'h0031, 16'h0040, 1'b1, 1'b0);
    st(5'h11, 16'h0032, S, S, 16'h0040, 16'h0031, 1'b1, 1'b1);
    $display("test set point and output types done");
    wr(PAE_A_HYST, 16'h0002);
    p(5'h08, 16'h000a, 16'h000b, 1'b1); p(5'h08, 16'h000a, 16'h0009, 1'b1);
    p(5'h08, 16'h000a, 16'h0008, 1'b0);
    wr(PAE_A_UPPER, 16'h0001);
    wr(PAE_A_LOWER, 16'h0001);
    p(5'h05, Z, S, 1'b0); p(5'h05, Z, 16'h0050, 1'b0);
    rd(PAE_A_STATUS, 16'h0006);
    $display("test hysteresis done");
    final_report();
  end
endmodule

`default_nettype wire

// ---- src/pae_evaluator.sv ----
// Process alarm evaluator: one alarm channel with register port
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - type 1: alarm outside independent deviation band
// - type 2: alarm when PV above SP by X
// - type 3: alarm when PV below SP by X
// - type 4: alarm while PV inside deviation band
// - types 5,6,7: types 1,2,3 plus standby
// - type 8: alarm when PV above X
// - type 9: alarm when PV below X
// - types 10,11: types 8,9 plus standby
// - type 12 loop break, first channel only
// - type 13: PV rate of change alarm
// - type 14: alarm when SP above X
// - type 15: alarm when SP below X
// - type 16: alarm when MV above X
// - type 17: alarm when MV below X
// - heating/cooling: upper MV alarm uses heating
// - heating/cooling: lower MV alarm uses cooling
// - band types hold separate upper, lower limits
// - standby band: overlapping hysteresis keeps alarm off
// - hysteresis only for types other than 0,12,13
module pae_evaluator
  import pae_pkg::*;
#(
  parameter int CHANNEL = 1
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [PAE_AW-1:0] reg_addr,
  input wire logic [PAE_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PAE_DW-1:0] reg_rdata,
  input wire logic sample_stb,
  input wire pae_proc_s proc,
  input wire logic loop_break_in,
  output logic alarm_out
);
  localparam int W = PAE_DW + 2;

  // Elaboration check: channels are numbered from 1
  if (CHANNEL < 1)
  begin
    $error("CHANNEL must be 1 or more");
  end

  typedef enum logic {PAE_SB_WAIT, PAE_SB_ARMED} pae_sb_e;

  function automatic logic signed [W-1:0] ext(input logic [PAE_DW-1:0] v);
    ext = {{2{v[PAE_DW-1]}}, v};
  endfunction

  logic [PAE_TW-1:0] type_reg;
  logic [PAE_DW-1:0] value_reg;
  logic [PAE_DW-1:0] upper_reg;
  logic [PAE_DW-1:0] lower_reg;
  logic [PAE_DW-1:0] hyst_reg;
  logic heatcool_reg;
  logic [PAE_DW-1:0] pv_prev_reg;
  logic alarm_reg;
  logic alarm_next;
  logic [PAE_DW-1:0] rdata_reg;
  pae_sb_e sb_reg;
  pae_sb_e sb_next;

  // Register decode
  wire logic wr_type = reg_wr && reg_addr == PAE_A_TYPE;
  wire logic wr_ctrl = reg_wr && reg_addr == PAE_A_CTRL;
  wire logic sb_restart = wr_ctrl && reg_wdata[PAE_C_SB_RESTART];
  wire logic [PAE_TW-1:0] new_type = reg_wdata[PAE_TW-1:0];
  wire logic type_ok = reg_wdata[PAE_DW-1:PAE_TW] == '0 && new_type <= PAE_T_MVLO
    && !(new_type == PAE_T_LOOP_BREAK && CHANNEL != 1);

  // Standby types map onto their plain counterparts
  wire logic is_sb = type_reg == PAE_T_BAND_SB || type_reg == PAE_T_UPDEV_SB
    || type_reg == PAE_T_LODEV_SB || type_reg == PAE_T_ABSHI_SB
    || type_reg == PAE_T_ABSLO_SB;
  wire logic [PAE_TW-1:0] base =
    type_reg == PAE_T_BAND_SB ? PAE_T_BAND :
    type_reg == PAE_T_UPDEV_SB ? PAE_T_UPDEV :
    type_reg == PAE_T_LODEV_SB ? PAE_T_LODEV :
    type_reg == PAE_T_ABSHI_SB ? PAE_T_ABSHI :
    type_reg == PAE_T_ABSLO_SB ? PAE_T_ABSLO : type_reg;

  wire logic hyst_on = type_reg != PAE_T_OFF && type_reg != PAE_T_LOOP_BREAK
    && type_reg != PAE_T_RATE;
  wire logic signed [W-1:0] pv = ext(proc.pv);
  wire logic signed [W-1:0] sp = ext(proc.sp);
  wire logic signed [W-1:0] dev = pv - sp;
  wire logic signed [W-1:0] xv = ext(value_reg);
  wire logic signed [W-1:0] hi = ext(upper_reg);
  wire logic signed [W-1:0] lo = ext(lower_reg);
  wire logic signed [W-1:0] hy = hyst_on ? ext(hyst_reg) : '0;
  wire logic signed [W-1:0] rate = pv - ext(pv_prev_reg);
  // Standard control has a single MV, carried on the heating lane
  wire logic signed [W-1:0] mv_hi = ext(proc.mv_heat);
  wire logic signed [W-1:0] mv_lo = heatcool_reg ? ext(proc.mv_cool)
    : ext(proc.mv_heat);
  wire logic overlap = base == PAE_T_BAND && hi + lo < hy + hy;

  // on_c turns the alarm on, stay_c keeps it on across the hysteresis zone
  logic on_c;
  logic stay_c;
  always_comb
  begin
    on_c = 1'b0;
    stay_c = 1'b0;
    case (base)
      PAE_T_BAND:
      begin
        on_c = dev > hi || dev < -lo;
        stay_c = dev > hi - hy || dev < hy - lo;
      end
      PAE_T_UPDEV:
      begin
        on_c = dev >= xv;
        stay_c = dev >= xv - hy;
      end
      PAE_T_LODEV:
      begin
        on_c = dev <= -xv;
        stay_c = dev <= hy - xv;
      end
      PAE_T_RANGE:
      begin
        on_c = dev <= hi && dev >= -lo;
        stay_c = dev <= hi + hy && dev >= -lo - hy;
      end
      PAE_T_ABSHI:
      begin
        on_c = pv > xv;
        stay_c = pv > xv - hy;
      end
      PAE_T_ABSLO:
      begin
        on_c = pv < xv;
        stay_c = pv < xv + hy;
      end
      PAE_T_LOOP_BREAK:
      begin
        on_c = loop_break_in;
        stay_c = loop_break_in;
      end
      PAE_T_RATE:
      begin
        on_c = xv >= 0 ? rate > xv : rate < xv;
        stay_c = on_c;
      end
      PAE_T_SPHI:
      begin
        on_c = sp > xv;
        stay_c = sp > xv - hy;
      end
      PAE_T_SPLO:
      begin
        on_c = sp < xv;
        stay_c = sp < xv + hy;
      end
      PAE_T_MVHI:
      begin
        on_c = mv_hi > xv;
        stay_c = mv_hi > xv - hy;
      end
      PAE_T_MVLO:
      begin
        on_c = mv_lo < xv;
        stay_c = mv_lo < xv + hy;
      end
      default:
      begin
        on_c = 1'b0;
        stay_c = 1'b0;
      end
    endcase
  end

  wire logic held = is_sb && sb_reg != PAE_SB_ARMED;
  assign alarm_next = (alarm_reg ? stay_c : on_c) && !overlap && !held;

  // Standby: arming (region left) wins over a restart in the same cycle
  wire logic arm_evt = sample_stb && !on_c;
  always_comb
  begin
    sb_next = sb_reg;
    case (sb_reg)
      PAE_SB_WAIT:
        if (arm_evt)
          sb_next = PAE_SB_ARMED;
      PAE_SB_ARMED:
        if ((sb_restart || wr_type) && !arm_evt)
          sb_next = PAE_SB_WAIT;
      default:
        sb_next = PAE_SB_WAIT;
    endcase
  end

  wire logic [PAE_DW-1:0] status = {{(PAE_DW-3){1'b0}}, overlap,
    sb_reg == PAE_SB_ARMED, alarm_reg};
  wire logic [PAE_DW-1:0] rd_mux =
    reg_addr == PAE_A_TYPE ? {{(PAE_DW-PAE_TW){1'b0}}, type_reg} :
    reg_addr == PAE_A_VALUE ? value_reg :
    reg_addr == PAE_A_UPPER ? upper_reg :
    reg_addr == PAE_A_LOWER ? lower_reg :
    reg_addr == PAE_A_HYST ? hyst_reg :
    reg_addr == PAE_A_CTRL ? {{(PAE_DW-1){1'b0}}, heatcool_reg} :
    reg_addr == PAE_A_STATUS ? status : '0;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      type_reg <= PAE_TYPE_RST;
      value_reg <= PAE_VALUE_RST;
      upper_reg <= PAE_VALUE_RST;
      lower_reg <= PAE_VALUE_RST;
      hyst_reg <= PAE_HYST_RST;
      heatcool_reg <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (wr_type && type_ok)
        type_reg <= new_type;
      if (reg_addr == PAE_A_VALUE)
        value_reg <= reg_wdata;
      if (reg_addr == PAE_A_UPPER)
        upper_reg <= reg_wdata;
      if (reg_addr == PAE_A_LOWER)
        lower_reg <= reg_wdata;
      if (reg_addr == PAE_A_HYST)
        hyst_reg <= reg_wdata;
      if (wr_ctrl)
        heatcool_reg <= reg_wdata[PAE_C_HEATCOOL];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      alarm_reg <= 1'b0;
      pv_prev_reg <= '0;
      sb_reg <= PAE_SB_WAIT;
      rdata_reg <= '0;
    end
    else
    begin
      sb_reg <= sb_next;
      rdata_reg <= reg_rd ? rd_mux : '0;
      if (sample_stb)
      begin
        alarm_reg <= alarm_next;
        pv_prev_reg <= proc.pv;
      end
    end
  end

  assign alarm_out = alarm_reg;
  assign reg_rdata = rdata_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_fresh(logic [PAE_TW-1:0] t);
    sample_stb && type_reg == t && !alarm_reg && !reg_wr;
  endsequence

  property p_updev;
    s_fresh(PAE_T_UPDEV) ##0 (dev >= xv) |=> alarm_out;
  endproperty
  a_updev: assert property (p_updev) else $error("upper deviation missed");

  property p_lodev;
    s_fresh(PAE_T_LODEV) ##0 (dev > -xv) |=> !alarm_out;
  endproperty
  a_lodev: assert property (p_lodev) else $error("lower deviation false");

  property p_abshi;
    s_fresh(PAE_T_ABSHI) ##0 (pv > xv) |=> alarm_out;
  endproperty
  a_abshi: assert property (p_abshi) else $error("absolute upper missed");

  property p_abslo;
    s_fresh(PAE_T_ABSLO) ##0 (pv >= xv) |=> !alarm_out;
  endproperty
  a_abslo: assert property (p_abslo) else $error("absolute lower false");

  property p_sphi;
    s_fresh(PAE_T_SPHI) ##0 (sp > xv) |=> alarm_out;
  endproperty
  a_sphi: assert property (p_sphi) else $error("set point upper missed");

  property p_mvlo;
    s_fresh(PAE_T_MVLO) ##0 (mv_lo < xv) |=> alarm_out;
  endproperty
  a_mvlo: assert property (p_mvlo) else $error("MV lower missed");

  property p_standby;
    sample_stb && is_sb && sb_reg == PAE_SB_WAIT |=> !alarm_out;
  endproperty
  a_standby: assert property (p_standby) else $error("standby let alarm out");

  property p_overlap;
    sample_stb && overlap |=> !alarm_out;
  endproperty
  a_overlap: assert property (p_overlap) else $error("overlap alarm on");

  property p_loop_break_chan;
    CHANNEL != 1 |-> type_reg != PAE_T_LOOP_BREAK;
  endproperty
  a_loop_break_chan: assert property (p_loop_break_chan) else $error("loop break on channel");

  property p_period;
    !sample_stb |=> $stable(alarm_out);
  endproperty
  a_period: assert property (p_period) else $error("alarm moved off sample");
endmodule

`default_nettype wire

// ---- src/pae_pkg.sv ----
// Constants, codes and carrier types of the process alarm evaluator
package pae_pkg;
  localparam int PAE_DW = 16;
  localparam int PAE_AW = 4;
  localparam int PAE_TW = 5;

  // Alarm type codes
  localparam logic [PAE_TW-1:0] PAE_T_OFF = 5'h00;
  localparam logic [PAE_TW-1:0] PAE_T_BAND = 5'h01;
  localparam logic [PAE_TW-1:0] PAE_T_UPDEV = 5'h02;
  localparam logic [PAE_TW-1:0] PAE_T_LODEV = 5'h03;
  localparam logic [PAE_TW-1:0] PAE_T_RANGE = 5'h04;
  localparam logic [PAE_TW-1:0] PAE_T_BAND_SB = 5'h05;
  localparam logic [PAE_TW-1:0] PAE_T_UPDEV_SB = 5'h06;
  localparam logic [PAE_TW-1:0] PAE_T_LODEV_SB = 5'h07;
  localparam logic [PAE_TW-1:0] PAE_T_ABSHI = 5'h08;
  localparam logic [PAE_TW-1:0] PAE_T_ABSLO = 5'h09;
  localparam logic [PAE_TW-1:0] PAE_T_ABSHI_SB = 5'h0a;
  localparam logic [PAE_TW-1:0] PAE_T_ABSLO_SB = 5'h0b;
  localparam logic [PAE_TW-1:0] PAE_T_LOOP_BREAK = 5'h0c;
  localparam logic [PAE_TW-1:0] PAE_T_RATE = 5'h0d;
  localparam logic [PAE_TW-1:0] PAE_T_SPHI = 5'h0e;
  localparam logic [PAE_TW-1:0] PAE_T_SPLO = 5'h0f;
  localparam logic [PAE_TW-1:0] PAE_T_MVHI = 5'h10;
  localparam logic [PAE_TW-1:0] PAE_T_MVLO = 5'h11;

  // Register word addresses
  localparam logic [PAE_AW-1:0] PAE_A_TYPE = 4'h0;
  localparam logic [PAE_AW-1:0] PAE_A_VALUE = 4'h1;
  localparam logic [PAE_AW-1:0] PAE_A_UPPER = 4'h2;
  localparam logic [PAE_AW-1:0] PAE_A_LOWER = 4'h3;
  localparam logic [PAE_AW-1:0] PAE_A_HYST = 4'h4;
  localparam logic [PAE_AW-1:0] PAE_A_CTRL = 4'h5;
  localparam logic [PAE_AW-1:0] PAE_A_STATUS = 4'h6;

  // Field positions
  localparam int PAE_C_HEATCOOL = 0;
  localparam int PAE_C_SB_RESTART = 1;
  localparam int PAE_S_ALARM = 0;
  localparam int PAE_S_ARMED = 1;
  localparam int PAE_S_OVERLAP = 2;

  // Reset values
  localparam logic [PAE_TW-1:0] PAE_TYPE_RST = 5'h02;
  localparam logic [PAE_DW-1:0] PAE_VALUE_RST = 16'h0000;
  localparam logic [PAE_DW-1:0] PAE_HYST_RST = 16'h0002;

  typedef struct packed {
    logic [PAE_DW-1:0] pv;
    logic [PAE_DW-1:0] sp;
    logic [PAE_DW-1:0] mv_heat;
    logic [PAE_DW-1:0] mv_cool;
  } pae_proc_s;
endpackage
